// File: qmec_host.sv
/*
  Host end: turns one request into one framed transfer, makes the serial
  clock by dividing ref_clk, and tracks whether the link is in 4-4-4 mode.
  Assumes request fields stay stable from req_start until req_done.
*/
`timescale 1ns/10ps
module qmec_host
  import qmec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  qmec_link_if.host link,
  input wire logic req_start,
  input wire logic [7:0] req_op,
  input wire logic req_skip_op,
  input wire logic req_addr_en,
  input wire logic [23:0] req_addr,
  input wire logic req_mode_en,
  input wire logic [7:0] req_mode,
  input wire logic [3:0] req_dummy,
  input wire logic req_quad,
  input wire logic [1:0] req_wr_bytes,
  input wire logic [15:0] req_wdata,
  input wire logic [7:0] req_rd_bytes,
  input wire logic req_flush,
  output logic req_ready,
  output logic req_refused,
  output logic req_done,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic qpi_active
);

  // Whole state of the host
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic [3:0] dq_m; // First sync stage
    logic [3:0] dq_s; // Second sync stage
    qmec_hphase_type ph;
    logic [3:0] div; // Half period counter
    logic [23:0] tx; // Outgoing bits, msb first
    logic [11:0] cnt; // Clocks left in phase
    logic [7:0] rx;
    logic [2:0] bitc;
    logic qpi;
    logic [7:0] prev_op;
    logic ready;
    logic done;
    logic refused;
    logic rd_valid;
    logic [7:0] rd_data;
    logic [3:0] dq_out;
    logic [3:0] dq_oe_n;
  } qmec_host_state_type;

  qmec_host_state_type r_reg, r_next;

  logic a_en, m_en, skip, quad; // Effective request
  logic [23:0] addr;
  logic [7:0] mode;
  logic [3:0] dum;
  logic [1:0] wr;
  logic [7:0] rd;
  logic [6:0] en; // Phase enables by phase code
  logic tick, w4, enter;
  logic [7:0] rx_n;
  logic [2:0] bitc_n;
  logic [11:0] bclk;
  qmec_hphase_type np;

  // Next state of the host
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.refused = 1'b0;
    r_next.rd_valid = 1'b0;
    r_next.dq_m = link.dq;
    r_next.dq_s = r_reg.dq_m;
    skip = req_skip_op | req_flush;
    a_en = req_addr_en | req_flush;
    m_en = req_mode_en | req_flush;
    quad = req_quad | req_flush;
    addr = req_flush ? ADDR_FLUSH : req_addr;
    mode = req_flush ? MODE_FLUSH : req_mode;
    dum = req_flush ? 4'h0 : req_dummy;
    wr = req_flush ? 2'h0 : req_wr_bytes;
    rd = req_flush ? 8'h00 : req_rd_bytes;
    en = {rd != 8'h00, wr != 2'h0, dum != 4'h0, m_en, a_en, !skip, 1'b0};
    tick = (r_reg.div == SCLK_HALF_LAST);
    w4 = r_reg.qpi | (quad & (r_reg.ph != H_OP));
    enter = 1'b0;
    bclk = BYTE_CLK_S;
    rx_n = w4 ? {r_reg.rx[3:0], r_reg.dq_s} : {r_reg.rx[6:0], r_reg.dq_s[1]};
    bitc_n = r_reg.bitc + (w4 ? 3'h4 : 3'h1);
    case (r_reg.ph)
      // Wait for a request
      H_IDLE: begin
        r_next.ready = 1'b1;
        if (req_start) begin
          if (!skip && ((req_op == OP_WRSR && r_reg.prev_op != OP_WREN) ||
              (req_op == OP_RST && r_reg.prev_op != OP_RST_EN))) begin
            r_next.refused = 1'b1;
          end else begin
            r_next.ready = 1'b0;
            r_next.cs_n = 1'b0;
            r_next.sclk = 1'b0;
            r_next.div = 4'h0;
            enter = 1'b1;
          end
        end
      end
      // Close the frame: clock low with select high, then finish
      H_END: begin
        r_next.div = r_reg.div + 4'h1;
        if (tick) begin
          r_next.div = 4'h0;
          if (!r_reg.cs_n) begin
            r_next.cs_n = 1'b1;
            r_next.sclk = 1'b0;
          end else begin
            r_next.ph = H_IDLE;
            r_next.done = 1'b1;
            r_next.ready = 1'b1;
            if (!skip) begin
              r_next.prev_op = req_op;
              if (req_op == OP_QPI_ON) begin
                r_next.qpi = 1'b1;
              end
              if (req_op == OP_QPI_OFF || req_op == OP_RST) begin
                r_next.qpi = 1'b0;
              end
            end
          end
        end
      end
      // Clock the active phases
      default: begin
        r_next.div = r_reg.div + 4'h1;
        if (tick) begin
          r_next.div = 4'h0;
          r_next.sclk = ~r_reg.sclk;
          if (!r_reg.sclk) begin
            // Rising edge: device samples, host takes read data
            if (r_reg.ph == H_RD) begin
              r_next.rx = rx_n;
              r_next.bitc = bitc_n;
              if (bitc_n == 3'h0) begin
                r_next.rd_data = rx_n;
                r_next.rd_valid = 1'b1;
              end
            end
            r_next.tx = w4 ? {r_reg.tx[19:0], 4'h0} : {r_reg.tx[22:0], 1'b0};
            r_next.cnt = r_reg.cnt - 12'h001;
            enter = (r_reg.cnt == 12'h001);
          end
        end
      end
    endcase
    // Pick the first enabled phase after the current one
    np = H_END;
    for (int i = 6; i >= 1; i--) begin
      if (i > int'(r_reg.ph) && en[i]) begin
        np = qmec_hphase_type'(i[2:0]);
      end
    end
    // Load the new phase
    if (enter) begin
      r_next.ph = np;
      w4 = r_reg.qpi | (quad & (np != H_OP));
      bclk = w4 ? BYTE_CLK_Q : BYTE_CLK_S;
      case (np)
        H_OP: begin
          r_next.tx = {req_op, 16'h0000};
          r_next.cnt = bclk;
        end
        H_ADDR: begin
          r_next.tx = addr;
          r_next.cnt = w4 ? ADDR_CLK_Q : ADDR_CLK_S;
        end
        H_MODE: begin
          r_next.tx = {mode, 16'h0000};
          r_next.cnt = bclk;
        end
        H_DUMMY: r_next.cnt = {8'h00, dum};
        H_WR: begin
          r_next.tx = {req_wdata, 8'h00};
          r_next.cnt = 12'(bclk * {10'h000, wr});
        end
        H_RD: begin
          r_next.bitc = 3'h0;
          r_next.cnt = 12'(bclk * {4'h0, rd});
        end
        default: r_next.cnt = 12'h000;
      endcase
    end
    // Drive lines while the clock is low
    w4 = r_next.qpi | (quad & (r_next.ph != H_OP));
    if (!r_next.sclk) begin
      case (r_next.ph)
        H_OP, H_ADDR, H_MODE, H_WR: begin
          r_next.dq_out = w4 ? r_next.tx[23:20] : {3'h7, r_next.tx[23]};
          r_next.dq_oe_n = w4 ? 4'h0 : 4'he;
        end
        default: begin
          r_next.dq_out = 4'hf;
          r_next.dq_oe_n = 4'hf;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.cs_n <= 1'b1;
      r_reg.dq_out <= 4'hf;
      r_reg.dq_oe_n <= 4'hf;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.sclk = r_reg.sclk;
  assign link.cs_n = r_reg.cs_n;
  assign link.host_dq_out = r_reg.dq_out;
  assign link.host_dq_oe_n = r_reg.dq_oe_n;
  assign req_ready = r_reg.ready;
  assign req_refused = r_reg.refused;
  assign req_done = r_reg.done;
  assign rd_data = r_reg.rd_data;
  assign rd_valid = r_reg.rd_valid;
  assign qpi_active = r_reg.qpi;

endmodule

// File: qmec_pkg.sv
/*
  Shared constants and types for the quad mode entry/exit control link:
  opcodes, status bit positions, phase lengths, parameter table contents
  and the state encodings of both ends.
  Assumes nothing of its surroundings; imported whole by the host, the device and the bench.
*/
package qmec_pkg;

  // Opcodes seen on the link
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_QPI_ON = 8'h38;
  localparam logic [7:0] OP_RD_PT = 8'h5a;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_QIO_RD = 8'heb;
  localparam logic [7:0] OP_QPI_OFF = 8'hff;

  // Status bit positions and reset values
  localparam int QUAD_EN_POS = 1;
  localparam int WEL_BIT = 1;
  localparam logic [7:0] S1_RST = 8'h00;
  localparam logic [7:0] S2_RST = 8'h00;
  localparam logic [1:0] S1_KEEP_BITS = 2'h0;

  // Continuous read mode byte patterns
  localparam logic [3:0] MODE_ENTER_NIB = 4'ha;
  localparam logic [7:0] MODE_FLUSH = 8'hff;
  localparam logic [23:0] ADDR_FLUSH = 24'hffffff;

  // Device phase lengths in received bits, dummy lengths in clocks
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [5:0] WR_BITS = 6'h10;
  localparam logic [5:0] QIO_DUMMY_CLKS = 6'h04;
  localparam logic [5:0] PT_DUMMY_CLKS = 6'h08;
  localparam logic [5:0] STEP_Q = 6'h04;
  localparam logic [5:0] STEP_S = 6'h01;

  // Host phase lengths in clocks
  localparam logic [11:0] BYTE_CLK_S = 12'h008;
  localparam logic [11:0] BYTE_CLK_Q = 12'h002;
  localparam logic [11:0] ADDR_CLK_S = 12'h018;
  localparam logic [11:0] ADDR_CLK_Q = 12'h006;
  localparam logic [3:0] SCLK_HALF_LAST = 4'h7;

  // Parameter table window, relative bytes 68h..6Fh
  localparam logic [23:0] PT_BASE = 24'h000068;
  localparam logic [23:0] PT_LEN = 24'h000008;
  localparam logic [7:0] PT_FILL = 8'hff;
  localparam logic [7:0] PT_DATA [0:7] = '{8'h19, 8'hf6, 8'hdd, 8'hff,
                                           8'he8, 8'h30, 8'hc0, 8'h80};

  // Device frame states
  typedef enum logic [2:0] {
    D_IDLE, D_CMD, D_ADDR, D_MODE, D_DUMMY, D_WDATA, D_RDATA, D_SKIP
  } qmec_dstate_type;

  // Source of read data
  typedef enum logic [1:0] {SRC_S1, SRC_S2, SRC_PT} qmec_src_type;

  // Host frame phases, in the order they are sent
  typedef enum logic [2:0] {
    H_IDLE, H_OP, H_ADDR, H_MODE, H_DUMMY, H_WR, H_RD, H_END
  } qmec_hphase_type;

endpackage

// File: qmec_link_if.sv
/*
  Link between host and device: serial clock, chip select and the four
  quad data lines, each line split into output and low-active enable.
  Assumes an idle line is pulled high when neither end enables it.
*/
`timescale 1ns/10ps
interface qmec_link_if;
  logic sclk; // Serial clock from the host
  logic cs_n; // Chip select, low during a frame
  logic [3:0] host_dq_out; // Host drive values
  logic [3:0] host_dq_oe_n; // Host enables, low drives
  logic [3:0] dev_dq_out; // Device drive values
  logic [3:0] dev_dq_oe_n; // Device enables, low drives
  logic [3:0] dq; // Resolved quad_data_lines

  // Resolve each line, pulled high when released
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!dev_dq_oe_n[i]) begin
        dq[i] = dev_dq_out[i];
      end else if (!host_dq_oe_n[i]) begin
        dq[i] = host_dq_out[i];
      end else begin
        dq[i] = 1'b1;
      end
    end
  end

  modport host (output sclk, output cs_n, output host_dq_out, output host_dq_oe_n, input dq);
  modport device (input sclk, input cs_n, input dq, output dev_dq_out, output dev_dq_oe_n);
endinterface

// File: qmec_device.sv
/*
  Device end: samples the link on ref_clk, decodes status, mode and
  parameter table commands, and keeps the quad enable, 4-4-4 and
  continuous read states.
  Assumes the host runs the serial clock at most an eighth of ref_clk,
  in clock mode 0, and keeps chip select high between frames.
*/
`timescale 1ns/10ps
// Behaviour
// - Quad enable bit 1 frees hold/protect
// - Opcode 05h returns first status register
// - Opcode 35h returns second status register
// - Write status second byte bit1 sets
// - Write status second byte bit1 clear clears
// - Mode byte Ax enters continuous read
// - Mode byte 00h exits after read
// - Eight Fh clocks force continuous exit
// - Opcode 38h enters 4-4-4 when enabled
// - Opcode FFh leaves 4-4-4 mode
// - Reset pair 66h/99h leaves 4-4-4
// - Table bytes 69h..6Bh are F6,DD,FF
// - Table byte 6Ch reads E8h
// - Host sends write enable before status
// - Host sends 66h then 99h separately
// - Quad reads need quad enable set
module qmec_device
  import qmec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  qmec_link_if.device link,
  output logic quad_enable_bit,
  output logic qpi_active,
  output logic cont_read_active
);

  // Whole state of the device
  typedef struct packed {
    logic [1:0] sclk_p; // Clock sync, [0] first stage
    logic sclk_d; // Clock one cycle later, for edges
    logic [1:0] cs_p; // Select sync, [0] first stage
    logic cs_d; // Select one cycle later
    logic [3:0] dq_m; // Data first sync stage
    logic [3:0] dq_s; // Data second sync stage
    qmec_dstate_type st; // Frame state
    qmec_src_type src; // Read data source
    logic quad_kind; // Address onward on four lines
    logic [23:0] sh; // Incoming shift register
    logic [5:0] cnt; // Bits or clocks in phase
    logic [23:0] addr; // Read address
    logic [7:0] tx; // Outgoing byte remainder
    logic [2:0] tcnt; // Bits already sent of byte
    logic [7:0] s1; // First status register
    logic [7:0] s2; // second_status_register
    logic wel; // Write enable latch
    logic qpi; // 4-4-4 mode
    logic cont; // Continuous read mode
    logic cont_pend; // Continuous mode for next frame
    logic rst_en; // Reset enable armed
    logic [3:0] dq_out; // Drive values
    logic [3:0] dq_oe_n; // Drive enables, low drives
  } qmec_dev_state_type;

  qmec_dev_state_type r_reg, r_next;

  logic rise; // Serial clock rising edge seen
  logic fall; // Serial clock falling edge seen
  logic w4; // Current phase uses four lines
  logic quad_en; // Quad enable bit value
  logic hold; // Hold pin pauses the frame
  logic [23:0] sh_n; // Shift register after this edge
  logic [5:0] cnt_n; // Bit count after this edge
  logic [7:0] cur; // Byte being sent
  logic [2:0] tcnt_n; // Sent count after this edge

  // Parameter table contents, fill outside the stored window
  function automatic logic [7:0] pt_byte(input logic [23:0] a);
    logic [23:0] off;
    off = a - PT_BASE;
    pt_byte = (off < PT_LEN) ? PT_DATA[off[2:0]] : PT_FILL;
  endfunction

  // Next state of the device
  always_comb begin
    r_next = r_reg;
    // Two stage synchronisers for every link input
    r_next.sclk_p = {r_reg.sclk_p[0], link.sclk};
    r_next.sclk_d = r_reg.sclk_p[1];
    r_next.cs_p = {r_reg.cs_p[0], link.cs_n};
    r_next.cs_d = r_reg.cs_p[1];
    r_next.dq_m = link.dq;
    r_next.dq_s = r_reg.dq_m;
    rise = r_reg.sclk_p[1] & ~r_reg.sclk_d;
    fall = ~r_reg.sclk_p[1] & r_reg.sclk_d;
    quad_en = r_reg.s2[QUAD_EN_POS];
    w4 = r_reg.qpi | (r_reg.quad_kind & (r_reg.st != D_CMD));
    hold = !quad_en && !w4 && !r_reg.dq_s[3];
    sh_n = w4 ? {r_reg.sh[19:0], r_reg.dq_s} : {r_reg.sh[22:0], r_reg.dq_s[0]};
    cnt_n = r_reg.cnt + (w4 ? STEP_Q : STEP_S);
    case (r_reg.src)
      SRC_S1: cur = r_reg.s1;
      SRC_S2: cur = r_reg.s2;
      default: cur = pt_byte(r_reg.addr);
    endcase
    if (r_reg.tcnt != 3'h0) begin
      cur = r_reg.tx;
    end
    tcnt_n = r_reg.tcnt + (w4 ? 3'h4 : 3'h1);
    if (r_reg.cs_p[1]) begin
      // Select high: release lines, end of frame
      r_next.st = D_IDLE;
      r_next.dq_oe_n = 4'hf;
      if (!r_reg.cs_d) begin
        r_next.cont = r_reg.cont_pend;
      end
    end else if (r_reg.st == D_IDLE) begin
      // Frame start; continuous mode skips the opcode
      r_next.cnt = 6'h00;
      r_next.sh = 24'h000000;
      r_next.tcnt = 3'h0;
      r_next.src = SRC_PT;
      r_next.quad_kind = r_reg.cont;
      r_next.cont_pend = 1'b0;
      r_next.st = r_reg.cont ? D_ADDR : D_CMD;
    end else if (rise && !hold) begin
      // Rising edge: take the next bits
      r_next.sh = sh_n;
      r_next.cnt = cnt_n;
      case (r_reg.st)
        // Opcode complete: decode
        D_CMD: begin
          if (cnt_n == CMD_BITS) begin
            r_next.cnt = 6'h00;
            r_next.st = D_SKIP;
            r_next.rst_en = 1'b0;
            case (sh_n[7:0])
              OP_WREN: r_next.wel = 1'b1;
              OP_RDSR1: begin
                r_next.src = SRC_S1;
                r_next.st = D_RDATA;
              end
              OP_RDSR2: begin
                r_next.src = SRC_S2;
                r_next.st = D_RDATA;
              end
              OP_WRSR: r_next.st = D_WDATA;
              OP_QPI_ON: begin
                if (quad_en) begin
                  r_next.qpi = 1'b1;
                end
              end
              OP_QPI_OFF: r_next.qpi = 1'b0;
              OP_RST_EN: r_next.rst_en = 1'b1;
              OP_RST: begin
                if (r_reg.rst_en) begin
                  r_next.qpi = 1'b0;
                  r_next.wel = 1'b0;
                  r_next.cont = 1'b0;
                end
              end
              OP_RD_PT: begin
                r_next.quad_kind = 1'b0;
                r_next.st = D_ADDR;
              end
              OP_QIO_RD: begin
                if (quad_en) begin
                  r_next.quad_kind = 1'b1;
                  r_next.st = D_ADDR;
                end
              end
              default: r_next.st = D_SKIP;
            endcase
          end
        end
        // Address complete
        D_ADDR: begin
          if (cnt_n == ADDR_BITS) begin
            r_next.addr = sh_n;
            r_next.cnt = 6'h00;
            r_next.st = r_reg.quad_kind ? D_MODE : D_DUMMY;
          end
        end
        // Mode byte complete
        D_MODE: begin
          if (cnt_n == MODE_BITS) begin
            r_next.cnt = 6'h00;
            r_next.st = D_DUMMY;
            r_next.cont_pend = (sh_n[7:4] == MODE_ENTER_NIB);
            if (r_reg.cont && r_reg.addr == ADDR_FLUSH && sh_n[7:0] == MODE_FLUSH) begin
              r_next.cont = 1'b0;
              r_next.st = D_SKIP;
            end
          end
        end
        // Dummy clocks
        D_DUMMY: begin
          r_next.cnt = r_reg.cnt + 6'h01;
          if (r_reg.cnt + 6'h01 == (r_reg.quad_kind ? QIO_DUMMY_CLKS : PT_DUMMY_CLKS)) begin
            r_next.cnt = 6'h00;
            r_next.st = D_RDATA;
          end
        end
        // Two status bytes complete
        D_WDATA: begin
          if (cnt_n == WR_BITS) begin
            r_next.st = D_SKIP;
            // protect pin only without quad enable
            if (r_reg.wel && (quad_en || r_reg.dq_s[2])) begin
              r_next.s1 = {sh_n[15:10], S1_KEEP_BITS};
              r_next.s2 = sh_n[7:0];
              r_next.wel = 1'b0;
            end
          end
        end
        default: r_next.st = r_reg.st;
      endcase
    end else if (fall && r_reg.st == D_RDATA) begin
      // Falling edge: present the next bits
      r_next.dq_out = w4 ? cur[7:4] : {2'h3, cur[7], 1'b1};
      r_next.dq_oe_n = w4 ? 4'h0 : 4'hd;
      r_next.tx = w4 ? {cur[3:0], 4'h0} : {cur[6:0], 1'b0};
      r_next.tcnt = tcnt_n;
      if (tcnt_n == 3'h0 && r_reg.src == SRC_PT) begin
        r_next.addr = r_reg.addr + 24'h000001;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.cs_p <= 2'h3;
      r_reg.cs_d <= 1'b1;
      r_reg.s1 <= S1_RST;
      r_reg.s2 <= S2_RST;
      r_reg.dq_out <= 4'hf;
      r_reg.dq_oe_n <= 4'hf;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.dev_dq_out = r_reg.dq_out;
  assign link.dev_dq_oe_n = r_reg.dq_oe_n;
  assign quad_enable_bit = r_reg.s2[QUAD_EN_POS];
  assign qpi_active = r_reg.qpi;
  assign cont_read_active = r_reg.cont;

endmodule

// File: qmec_link_monitor.sv
/* Wire checker for the qmec link between host and device.
   Assumes plain connections to the link signals, made beside it. */
`timescale 1ns/10ps
module qmec_link_monitor (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] host_dq_out,
  input wire logic [3:0] host_dq_oe_n,
  input wire logic [3:0] dev_dq_out,
  input wire logic [3:0] dev_dq_oe_n,
  input wire logic [3:0] dq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // One high phase of the serial clock
  sequence s_half_high;
    sclk [*8] ##1 !sclk;
  endsequence
  // Setup time at the start of a frame
  sequence s_open_low;
    !sclk [*8] ##1 sclk;
  endsequence
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  AST_SCLK_HALF: assert property ($rose(sclk) |-> s_half_high)
    else $error("serial clock high phase not 8 cycles");
  AST_FRAME_OPEN: assert property ($fell(cs_n) |-> s_open_low)
    else $error("first rise not 8 cycles after select");
  AST_FRAME_CLOSE: assert property ($rose(cs_n) |-> !sclk && $past(sclk))
    else $error("select not released with the last clock fall");
  AST_NO_CLASH: assert property ((~host_dq_oe_n & ~dev_dq_oe_n) == 4'h0)
    else $error("both ends drive one data line");
  AST_DEV_RELEASE: assert property (cs_n [*8] |-> dev_dq_oe_n == 4'hf)
    else $error("device drives lines while deselected");
  AST_HOST_HOLD: assert property (sclk && $past(sclk) |-> $stable(host_dq_out))
    else $error("host data moved while clock high");
  AST_DEV_HOLD: assert property (sclk && !cs_n |-> $stable(dev_dq_out))
    else $error("device data moved while clock high");
endmodule

// File: tb_quad_mode_entry_exit_control.sv
/* Bench: qmec host and device on one link, a second device on a raw link.
   Assumes the package, interface, design and monitor compiled first. */
`timescale 1ns/10ps
module tb_quad_mode_entry_exit_control;
  import qmec_pkg::*;
  logic ref_clk = 0, sys_rst = 1, req_start = 0, skip = 0, aen = 0, men = 0;
  logic quad = 0, flush = 0, ready, refused, done, rd_valid, h_qpi, qen, d_qpi, cont, qen2;
  logic [2:0] pins_hi = 3'h7;
  logic [7:0] op = 0, mode = 0, rb = 0, rd_data;
  logic [23:0] addr = 0;
  logic [3:0] dummy = 0;
  logic [1:0] wb = 0;
  logic [15:0] wd = 0;
  logic [7:0] got [$];
  logic [7:0] ent [2] = '{8'ha5, 8'ha3};
  logic [7:0] pt_exp [4] = '{8'hf6, 8'hdd, 8'hff, 8'he8};
  int miscompares = 0, checks = 0, rises = 0;
  qmec_link_if link ();
  qmec_link_if link2 ();
  qmec_host qmec_host_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
    .req_start(req_start), .req_op(op), .req_skip_op(skip), .req_addr_en(aen),
    .req_addr(addr), .req_mode_en(men), .req_mode(mode), .req_dummy(dummy),
    .req_quad(quad), .req_wr_bytes(wb), .req_wdata(wd), .req_rd_bytes(rb),
    .req_flush(flush), .req_ready(ready), .req_refused(refused), .req_done(done),
    .rd_data(rd_data), .rd_valid(rd_valid), .qpi_active(h_qpi));
  qmec_device qmec_device_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
    .quad_enable_bit(qen), .qpi_active(d_qpi), .cont_read_active(cont));
  qmec_device qmec_device_inst2 (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link2),
    .quad_enable_bit(qen2), .qpi_active(), .cont_read_active());
  qmec_link_monitor qmec_link_monitor_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .sclk(link.sclk), .cs_n(link.cs_n), .host_dq_out(link.host_dq_out),
    .host_dq_oe_n(link.host_dq_oe_n), .dev_dq_out(link.dev_dq_out),
    .dev_dq_oe_n(link.dev_dq_oe_n), .dq(link.dq));
  // Clock and serial clock rise counter
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge link.sclk) rises++;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One falling edge, cut short after a bounded count
  task automatic tick(inout int n);
    @(negedge ref_clk);
    n++;
    if (n > 9000) begin
      miscompares++;
      final_report();
    end
  endtask
  // One request: wait ready, start, collect bytes until done or refused
  task automatic run();
    int n;
    n = 0;
    while (ready !== 1'b1) tick(n);
    got.delete();
    rises = 0;
    req_start = 1;
    tick(n);
    req_start = 0;
    while (done !== 1'b1 && refused !== 1'b1) begin
      if (rd_valid === 1'b1) got.push_back(rd_data);
      tick(n);
    end
  endtask
  task automatic cmd(input logic [7:0] o, input logic [15:0] d, input logic [1:0] w,
                     input logic [7:0] r);
    {op, wd, wb, rb} = {o, d, w, r};
    {aen, men, dummy, skip, flush, quad} = {8'h00, h_qpi};
    run();
  endtask
  task automatic qrd(input logic [7:0] o, input logic s, input logic [23:0] a,
                     input logic [7:0] m, input logic [3:0] dm, input logic [7:0] r);
    {op, skip, addr, mode, dummy, rb, aen, wb, flush} = {o, s, a, m, dm, r, 4'h8};
    men = (o == OP_QIO_RD);
    quad = (o == OP_QIO_RD) | h_qpi;
    run();
  endtask
  // Raw single-line frame on the second link, msb first on line 0
  task automatic raw(input logic [23:0] v, input int nb);
    link2.cs_n = 0;
    for (int i = nb * 8 - 1; i >= 0; i--) begin
      link2.host_dq_out = {pins_hi, v[i]};
      repeat (8) @(negedge ref_clk);
      link2.sclk = 1;
      repeat (8) @(negedge ref_clk);
      link2.sclk = 0;
    end
    repeat (8) @(negedge ref_clk);
    link2.cs_n = 1;
    repeat (16) @(negedge ref_clk);
  endtask
  initial begin
    {link2.sclk, link2.cs_n, link2.host_dq_out, link2.host_dq_oe_n} = 10'h11e;
    repeat (10) @(negedge ref_clk);
    sys_rst = 0;
    repeat (2) @(negedge ref_clk);
    chk("quad en rst", 8'h00, {7'h0, qen});
    cmd(OP_RDSR1, 0, 0, 1);
    chk("sr1", 8'h00, got[0]);
    chk("sr1 rises", 8'h10, rises[7:0]);
    chk("idle dq", 8'h0f, {4'h0, link.dq});
    qrd(OP_QIO_RD, 0, 24'h00006c, 8'ha5, 4, 1);
    chk("noqe cont", 8'h00, {7'h0, cont});
    cmd(OP_WRSR, 16'h0002, 2, 0);
    chk("wrsr refused", 8'h01, {7'h0, refused});
    cmd(OP_WREN, 0, 0, 0);
    cmd(OP_WRSR, 16'h0002, 2, 0);
    chk("quad en set", 8'h01, {7'h0, qen});
    cmd(OP_RDSR2, 0, 0, 1);
    chk("status2", 8'h02, got[0]);
    foreach (ent[i]) begin
      qrd(OP_QIO_RD, 0, 24'h00006c, ent[i], 4, 1);
      chk("qio byte", 8'he8, got[0]);
      chk("cont on", 8'h01, {7'h0, cont});
      if (i == 0) begin
        qrd(OP_QIO_RD, 1, 24'h00006d, 8'h00, 4, 1);
        chk("cont byte", 8'h30, got[0]);
      end else begin
        flush = 1;
        run();
        chk("flush rises", 8'h08, rises[7:0]);
      end
      chk("cont off", 8'h00, {7'h0, cont});
    end
    qrd(OP_RD_PT, 0, 24'h000069, 0, 8, 4);
    for (int i = 0; i < 4; i++) chk("table", pt_exp[i], got[i]);
    cmd(OP_QPI_ON, 0, 0, 0);
    chk("qpi on", 8'h01, {7'h0, d_qpi});
    cmd(OP_RDSR2, 0, 0, 1);
    chk("qpi status2", 8'h02, got[0]);
    chk("qpi rises", 8'h04, rises[7:0]);
    cmd(OP_QPI_OFF, 0, 0, 0);
    chk("qpi off", 8'h00, {7'h0, d_qpi});
    cmd(OP_QPI_ON, 0, 0, 0);
    cmd(OP_RST, 0, 0, 0);
    chk("rst refused", 8'h01, {7'h0, refused});
    cmd(OP_RST_EN, 0, 0, 0);
    cmd(OP_RST, 0, 0, 0);
    chk("rst qpi", 8'h00, {6'h0, d_qpi, h_qpi});
    cmd(OP_WREN, 0, 0, 0);
    cmd(OP_WRSR, 16'h0000, 2, 0);
    chk("quad en clear", 8'h00, {7'h0, qen});
    raw(24'h010002, 3);
    chk("raw no wren", 8'h00, {7'h0, qen2});
    raw(24'h000006, 1);
    raw(24'h010002, 3);
    chk("raw wren", 8'h01, {7'h0, qen2});
    // Hold and protect lines driven low from here on
    {pins_hi, link2.host_dq_oe_n} = 7'h12;
    raw(24'h000006, 1);
    raw(24'h010000, 3);
    chk("raw pins freed", 8'h00, {7'h0, qen2});
    raw(24'h000006, 1);
    raw(24'h010002, 3);
    chk("raw pins held", 8'h00, {7'h0, qen2});
    final_report();
  end
endmodule
